// file: src/srv_bar_unit.sv
// legality, readback and address claim for one function's six vf bars
// assumes setup and bases come from registers; purely combinational
`timescale 1ns/1ns
`default_nettype none

module srv_bar_unit
  import srv_pkg::*;
(
  input  wire srv_bar_s     cfg  [BARS],
  input  wire logic [31:0]  base [BARS],
  input  wire logic [1:0]   port,
  input  wire logic [63:0]  addr,
  input  wire logic         io,
  input  wire logic [2:0]   vf_idx,
  output logic [BARS-1:0]   ok,
  output logic [BARS-1:0]   is_io,
  output logic [31:0]       rb   [BARS],
  output logic              hit,
  output logic [2:0]        hit_bar
);

  // whether a slot setup may be used at all
  function automatic logic bar_legal(input srv_bar_s c,
                                     input logic [1:0] pt,
                                     input logic last);
    logic       leg;
    logic [5:0] lo;
    logic [5:0] hi;
    leg = (pt == PORT_LEGACY);
    lo  = leg ? SZ_MIN_LEG : SZ_MIN_EP; // see RL20
    hi  = c.b64 ? SZ_MAX_64 : SZ_MAX_32; // see RL17
    if (!c.en || pt == PORT_ROOT) // see RL12
      return 1'b0;
    if (c.io) // see RL16
      return leg && !c.b64 && !c.pref
             && c.size >= SZ_MIN_LEG && c.size <= SZ_MAX_32;
    if (c.b64 && last)
      return 1'b0;
    if (!leg && c.pref && !c.b64 && !last) // see RL19
      return 1'b0;
    return c.size >= lo && c.size <= hi;
  endfunction

  function automatic logic [63:0] mask64(input logic [5:0] sz);
    return ~((64'h1 << sz) - 64'h1);
  endfunction

  // walk the six slots; a legal 64-bit slot swallows the next one
  always_comb
  begin
    logic        up;
    logic [63:0] m;
    logic [63:0] b;
    logic [63:0] rel;
    up      = 1'b0;
    m       = '0;
    b       = '0;
    rel     = '0;
    ok      = '0;
    is_io   = '0;
    hit     = 1'b0;
    hit_bar = 3'h0;
    for (int i = 0; i < BARS; i++)
    begin
      rb[i]    = '0; // see RL23
      is_io[i] = cfg[i].io;
      if (up)
      begin
        rb[i] = base[i] & m[63:32]; // see RL15
        up    = 1'b0;
      end
      else
      begin
        ok[i] = bar_legal(cfg[i], port, i == BARS - 1); // see RL14
        m     = mask64(cfg[i].size);
        if (ok[i])
        begin
          if (cfg[i].io)
            rb[i] = (base[i] & m[31:0] & IO_MASK) | 32'h1;
          else
            rb[i] = (base[i] & m[31:0] & MEM_MASK)
                    | {28'h0, cfg[i].pref, cfg[i].b64, 2'h0};
          up  = cfg[i].b64;
          b   = {cfg[i].b64 ? base[(i + 1) % BARS] : 32'h0, base[i]} & m;
          rel = addr - b;
          // each vf owns one aperture, stacked from the base
          if (!hit && cfg[i].io == io // see RL18
              && (rel >> cfg[i].size) == {61'h0, vf_idx})
          begin
            hit     = 1'b1;
            hit_bar = 3'(i);
          end
        end
      end
    end
  end

endmodule

`default_nettype wire

// file: src/srv_pkg.sv
// shared constants and carriers for the virtual function map block
// assumes one 20 MHz clock and a plain word-addressed register port
package srv_pkg;

  // register port address width and word map
  localparam int          ADDR_W      = 10;
  localparam logic [2:0]  BLK_GLOBAL  = 3'h0;
  localparam logic [2:0]  BLK_PF0     = 3'h1;
  localparam logic [2:0]  BLK_PF1     = 3'h2;
  localparam logic [4:0]  GW_CTRL     = 5'h00;
  localparam logic [4:0]  GW_VFCNT    = 5'h01;
  localparam logic [4:0]  GW_STATUS   = 5'h02;
  localparam logic [4:0]  LW_CAPVER   = 5'h00;
  localparam logic [4:0]  LW_DEVID    = 5'h01;
  localparam logic [4:0]  LW_PAGE     = 5'h02;
  localparam logic [4:0]  LW_MTBL     = 5'h03;
  localparam logic [4:0]  LW_MTOFF    = 5'h04;
  localparam logic [4:0]  LW_MPOFF    = 5'h05;
  localparam logic [1:0]  LW_BAR_CFG  = 2'h1;
  localparam logic [1:0]  LW_BAR_BASE = 2'h2;

  // field positions
  localparam int CTRL_SRIOV    = 2;
  localparam int CTRL_PF1      = 3;
  localparam int CTRL_FLR      = 4;
  localparam int VFCNT_PF1_LSB = 4;
  localparam int MSIX_EN_BIT   = 16;
  localparam int ST_CNT_ERR    = 16;
  localparam int ST_PRESENT    = 17;
  localparam int ST_FLR        = 19;
  localparam int ST_MSIX_BAD   = 20;

  // port type codes
  localparam logic [1:0] PORT_EP     = 2'h0;
  localparam logic [1:0] PORT_LEGACY = 2'h1;
  localparam logic [1:0] PORT_ROOT   = 2'h2;

  // function numbering
  localparam logic [7:0] PF0_FN      = 8'h00;
  localparam logic [7:0] PF1_FN      = 8'h01;
  localparam logic [7:0] VF_FIRST_FN = 8'h40;
  localparam logic [7:0] VF_LAST_FN  = 8'h45;
  localparam logic [2:0] VF_SLOTS    = 3'h6;

  // bar slots and aperture limits as log2 of bytes
  localparam int         BARS       = 6;
  localparam logic [5:0] SZ_MIN_EP  = 6'h07;
  localparam logic [5:0] SZ_MIN_LEG = 6'h04;
  localparam logic [5:0] SZ_MAX_32  = 6'h1F;
  localparam logic [5:0] SZ_MAX_64  = 6'h26;
  localparam logic [31:0] IO_MASK   = 32'hFFFF_FFFC;
  localparam logic [31:0] MEM_MASK  = 32'hFFFF_FFF0;

  // reset values
  localparam logic [4:0]  CTRL_RST   = 5'h00;
  localparam logic [3:0]  CAPVER_RST = 4'h1;
  localparam logic [31:0] PAGE_RST   = 32'h0000_0001;

  // bar setup word, size in low bits
  typedef struct packed {
    logic       en;
    logic       io;
    logic       b64;
    logic       pref;
    logic [5:0] size;
  } srv_bar_s;

  typedef struct packed {
    logic        io;
    logic [7:0]  fn;
    logic [63:0] addr;
  } srv_req_s;

  typedef struct packed {
    logic       mapped;
    logic       is_vf;
    logic       pf;
    logic [2:0] vf_idx;
    logic       claimed;
    logic [2:0] bar;
  } srv_ans_s;

endpackage

// file: src/srv_sriov_map.sv
// virtual function map, offsets, capability fields and vf bar setup
// assumes a plain register port on mclk and lookups from the same clock
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// RL1: virtual functions live at function numbers 64 to 69, six slots
// RL2: vf counts of both functions together never exceed six
// RL3: vfs numbered consecutively, first function's vfs before second's
// RL4: first function is number 0, second function is number 1
// RL5: first vf offset is first vf number minus own function number
// RL6: first function's offset is 64 when it owns any vf
// RL7: second function's offset is 63 plus first function's vf count
// RL8: each function holds a four bit capability version
// RL9: each function holds one 16 bit vf device id for all its vfs
// RL10: 32 bit page size field, bit n means pages of 2^(n+12)
// RL11: capability present on first function, and second when enabled
// RL12: no capability and no vf bars in root port mode
// RL13: function reset only allowed in endpoint modes
// RL14: six 32 bit bars or three 64 bit bars per function
// RL15: a 64 bit bar uses the next slot for its upper address
// RL16: io bars are 32 bit, not prefetchable, legacy endpoint only
// RL17: apertures up to 2 GB for 32 bit and io, 256 GB for 64 bit
// RL18: a bar claims only requests of its own space type
// RL19: non legacy prefetchable bars must be 64 bit except slot five
// RL20: least aperture 128 bytes endpoint, 16 bytes legacy endpoint
// RL21: msi-x needs a memory bar; the application keeps table and pba
// RL22: msi-x gives table size, offsets and bar indicators, lower slot
// RL23: a disabled bar decodes nothing and reads back zero
module srv_sriov_map
  import srv_pkg::*;
#(
  parameter logic [15:0] VF_DEVICE_ID = 16'h5A5A // arbitrary value
)
(
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  input  wire logic              req_valid,
  input  wire srv_req_s          req,
  output logic                   ans_valid,
  output srv_ans_s               ans,
  output logic [1:0]             sriov_present,
  output logic                   flr_enable,
  output logic                   vf_count_err
);

  // vf count limit and second count after the first has its share
  function automatic logic [2:0] clamp_cnt(input logic [2:0] c,
                                           input logic [2:0] room);
    return (c > room) ? room : c;
  endfunction

  // distance from a function to its first vf, zero when it has none
  function automatic logic [7:0] vf_offset(input logic [2:0] n,
                                           input logic [7:0] first,
                                           input logic [7:0] pf);
    return (n == 3'h0) ? 8'h00 : first - pf;
  endfunction

  // msi-x indicator must name a usable memory bar lower slot
  function automatic logic bir_ok(input logic [2:0]      bir,
                                  input logic [BARS-1:0] ok,
                                  input logic [BARS-1:0] io);
    if (bir >= 3'(BARS))
      return 1'b0;
    return ok[bir] && !io[bir];
  endfunction

  // function number to owner and vf index
  function automatic srv_ans_s map_fn(input logic [7:0] fn,
                                      input logic [2:0] n0,
                                      input logic [2:0] n1,
                                      input logic       pf1,
                                      input logic       act);
    srv_ans_s   a;
    logic [7:0] rel;
    a   = '0;
    rel = fn - VF_FIRST_FN;
    if (fn == PF0_FN) // see RL4
      a.mapped = 1'b1;
    else if (fn == PF1_FN && pf1) // see RL4
    begin
      a.mapped = 1'b1;
      a.pf     = 1'b1;
    end
    else if (act && fn >= VF_FIRST_FN && fn <= VF_LAST_FN) // see RL1
    begin
      if (rel < {5'h0, n0}) // see RL3
      begin
        a.mapped = 1'b1;
        a.is_vf  = 1'b1;
        a.vf_idx = rel[2:0];
      end
      else if (rel < {5'h0, n0} + {5'h0, n1}) // see RL3
      begin
        a.mapped = 1'b1;
        a.is_vf  = 1'b1;
        a.pf     = 1'b1;
        a.vf_idx = rel[2:0] - n0;
      end
    end
    return a;
  endfunction

  // registers
  logic [4:0]  ctrl_q;
  logic [2:0]  cnt0_q;
  logic [2:0]  cnt1_q;
  logic [3:0]  capver_q   [2];
  logic [15:0] devid_q    [2];
  logic [31:0] page_q     [2];
  logic [16:0] mtbl_q     [2];
  logic [31:0] mtoff_q    [2];
  logic [31:0] mpoff_q    [2];
  srv_bar_s    bar_cfg_q  [2][BARS];
  logic [31:0] bar_base_q [2][BARS];
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        ans_valid_q;
  srv_ans_s    ans_q;
  srv_ans_s    ans_d;
  logic [1:0]  present_q;
  logic        flr_q;
  logic        cnt_err_q;

  // per-function bar unit results
  logic [BARS-1:0] bar_ok  [2];
  logic [BARS-1:0] bar_io  [2];
  logic [31:0]     bar_rb  [2][BARS];
  logic [1:0]      bar_hit;
  logic [2:0]      bar_sel [2];

  // address decode
  wire [2:0] blk      = reg_addr[9:7];
  wire [4:0] word     = reg_addr[6:2];
  wire       glob     = (blk == BLK_GLOBAL);
  wire       pf_sel   = (blk == BLK_PF0) || (blk == BLK_PF1);
  wire       pf_i     = (blk == BLK_PF1);
  wire [2:0] slot     = word[2:0];
  wire       slot_ok  = (slot < 3'(BARS));
  wire       cfg_sel  = (word[4:3] == LW_BAR_CFG) && slot_ok;
  wire       base_sel = (word[4:3] == LW_BAR_BASE) && slot_ok;
  wire       glob_wr  = reg_wr && glob;
  wire       pf_wr    = reg_wr && pf_sel;

  // mode decode
  wire [1:0] port     = ctrl_q[1:0];
  wire       not_root = (port != PORT_ROOT);
  wire       active   = ctrl_q[CTRL_SRIOV] && not_root; // see RL12
  wire       pf1_on   = ctrl_q[CTRL_PF1];
  wire       flr_eff  = ctrl_q[CTRL_FLR] && not_root; // see RL13

  // effective vf counts, total held to six
  wire [2:0] n0       = clamp_cnt(cnt0_q, VF_SLOTS); // see RL2
  wire [2:0] n1       = pf1_on ? clamp_cnt(cnt1_q, VF_SLOTS - n0) : 3'h0;
  wire       cnt_err  = ({1'b0, cnt0_q} + {1'b0, cnt1_q} > {1'b0, VF_SLOTS})
                        || (!pf1_on && cnt1_q != 3'h0); // see RL2

  // first vf offsets; second starts right after the first's vfs
  wire [7:0] ofs0     = vf_offset(n0, VF_FIRST_FN, PF0_FN); // see RL6
  wire [7:0] ofs1     = vf_offset(n1, VF_FIRST_FN + {5'h0, n0},
                                  PF1_FN); // see RL7

  // msi-x sanity per function; table and pba live in the application
  wire [1:0] msix_bad;

  // capability presence per function
  wire [1:0] present  = {active && pf1_on, active}; // see RL11

  // status word
  wire [31:0] status  = {10'h0, msix_bad, flr_eff, present, cnt_err,
                         ofs1, ofs0};

  // request lookup
  wire srv_ans_s map_w = map_fn(req.fn, n0, n1, pf1_on, active);

  // one bar unit per physical function
  for (genvar g = 0; g < 2; g++)
  begin : g_pf
    srv_bar_unit u_bar (
      .cfg     (bar_cfg_q[g]),
      .base    (bar_base_q[g]),
      .port    (port),
      .addr    (req.addr),
      .io      (req.io),
      .vf_idx  (map_w.vf_idx),
      .ok      (bar_ok[g]),
      .is_io   (bar_io[g]),
      .rb      (bar_rb[g]),
      .hit     (bar_hit[g]),
      .hit_bar (bar_sel[g])
    );
    assign msix_bad[g] = mtbl_q[g][MSIX_EN_BIT]
                         && !(bir_ok(mtoff_q[g][2:0], bar_ok[g], bar_io[g])
                         && bir_ok(mpoff_q[g][2:0], bar_ok[g],
                                   bar_io[g])); // see RL21
  end

  // answer: owner from the map, claim from the owner's vf bars
  always_comb
  begin
    ans_d         = map_w;
    ans_d.claimed = active && map_w.is_vf && bar_hit[map_w.pf];
    ans_d.bar     = ans_d.claimed ? bar_sel[map_w.pf] : 3'h0;
  end

  // global control writes
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_q <= CTRL_RST;
      cnt0_q <= 3'h0;
      cnt1_q <= 3'h0;
    end
    else if (glob_wr && word == GW_CTRL)
    begin
      ctrl_q[4:2] <= reg_wdata[4:2];
      if (reg_wdata[1:0] != 2'h3) // reserved port code ignored
        ctrl_q[1:0] <= reg_wdata[1:0];
    end
    else if (glob_wr && word == GW_VFCNT)
    begin
      cnt0_q <= reg_wdata[2:0];
      cnt1_q <= reg_wdata[VFCNT_PF1_LSB +: 3];
    end
  end

  // per-function capability fields
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int p = 0; p < 2; p++)
      begin
        capver_q[p] <= CAPVER_RST;
        devid_q[p]  <= VF_DEVICE_ID;
        page_q[p]   <= PAGE_RST;
        mtbl_q[p]   <= '0;
        mtoff_q[p]  <= '0;
        mpoff_q[p]  <= '0;
      end
    end
    else if (pf_wr)
    begin
      case (word)
        LW_CAPVER: capver_q[pf_i] <= reg_wdata[3:0]; // see RL8
        LW_DEVID:  devid_q[pf_i]  <= reg_wdata[15:0]; // see RL9
        LW_PAGE:   page_q[pf_i]   <= reg_wdata; // see RL10
        LW_MTBL:   mtbl_q[pf_i]   <= {reg_wdata[MSIX_EN_BIT], 5'h0,
                                      reg_wdata[10:0]}; // see RL22
        LW_MTOFF:  mtoff_q[pf_i]  <= reg_wdata; // see RL22
        LW_MPOFF:  mpoff_q[pf_i]  <= reg_wdata; // see RL22
        default:   ;
      endcase
    end
  end

  // vf bar setup and base writes
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int p = 0; p < 2; p++)
      begin
        for (int i = 0; i < BARS; i++)
        begin
          bar_cfg_q[p][i]  <= '0;
          bar_base_q[p][i] <= '0;
        end
      end
    end
    else if (pf_wr && cfg_sel)
      bar_cfg_q[pf_i][slot] <= srv_bar_s'(reg_wdata[9:0]);
    else if (pf_wr && base_sel)
      bar_base_q[pf_i][slot] <= reg_wdata;
  end

  // read selection
  always_comb
  begin
    rdata_d = '0;
    if (reg_rd && glob)
    begin
      case (word)
        GW_CTRL:   rdata_d = {27'h0, ctrl_q};
        GW_VFCNT:  rdata_d = {25'h0, cnt1_q, 1'b0, cnt0_q};
        GW_STATUS: rdata_d = status; // see RL5
        default:   rdata_d = '0;
      endcase
    end
    else if (reg_rd && pf_sel)
    begin
      case (word)
        LW_CAPVER: rdata_d = {28'h0, capver_q[pf_i]};
        LW_DEVID:  rdata_d = {16'h0, devid_q[pf_i]};
        LW_PAGE:   rdata_d = page_q[pf_i];
        LW_MTBL:   rdata_d = {15'h0, mtbl_q[pf_i]};
        LW_MTOFF:  rdata_d = mtoff_q[pf_i];
        LW_MPOFF:  rdata_d = mpoff_q[pf_i];
        default:
        begin
          if (cfg_sel)
            rdata_d = {22'h0, bar_cfg_q[pf_i][slot]};
          else if (base_sel)
            rdata_d = bar_rb[pf_i][slot]; // see RL23
          else
            rdata_d = '0;
        end
      endcase
    end
  end

  // read data and lookup answer, one cycle after the strobe
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata_q     <= '0;
      ans_valid_q <= 1'b0;
      ans_q       <= '0;
    end
    else
    begin
      rdata_q     <= rdata_d;
      ans_valid_q <= req_valid;
      ans_q       <= req_valid ? ans_d : '0;
    end
  end

  // mode status outputs
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      present_q <= 2'h0;
      flr_q     <= 1'b0;
      cnt_err_q <= 1'b0;
    end
    else
    begin
      present_q <= present;
      flr_q     <= flr_eff;
      cnt_err_q <= cnt_err;
    end
  end

  assign reg_rdata     = rdata_q;
  assign ans_valid     = ans_valid_q;
  assign ans           = ans_q;
  assign sriov_present = present_q;
  assign flr_enable    = flr_q;
  assign vf_count_err  = cnt_err_q;

endmodule

`default_nettype wire

// file: test/srv_host_model.sv
// host side lookup requester holding the msi-x structures
// assumes answers come one mclk cycle after the request edge
`timescale 1ns/1ns
`default_nettype none

module srv_host_model
  import srv_pkg::*;
(
  input  wire logic     mclk,
  output logic          req_valid,
  output srv_req_s      req,
  input  wire logic     ans_valid,
  input  wire srv_ans_s ans
);
  logic [31:0] msix_store [8]; // vector table and pba kept here

  // idle at time zero
  initial
  begin
    req_valid  = 1'b0;
    req        = '0;
    msix_store = '{default: 32'h0};
  end

  // one request, answer taken in the cycle it stands
  task automatic lookup(input  logic        io,
                        input  logic [7:0]  fn,
                        input  logic [63:0] a,
                        output srv_ans_s    r);
    @(posedge mclk);
    req_valid <= 1'b1;
    req       <= {io, fn, a};
    @(posedge mclk);
    req_valid <= 1'b0;
    req       <= ~{io, fn, a}; // released lines do not hold
    @(posedge mclk);
    r = (ans_valid === 1'b1) ? ans : '1;
  endtask
endmodule

`default_nettype wire

// file: test/srv_map_sva.sv
// port checker for the virtual function map block
// assumes one mclk domain with rstn active low
`timescale 1ns/1ns
`default_nettype none

module srv_map_chk
  import srv_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rstn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [31:0]       reg_rdata,
  input wire logic              req_valid,
  input wire srv_req_s          req,
  input wire logic              ans_valid,
  input wire srv_ans_s          ans,
  input wire logic [1:0]        sriov_present,
  input wire logic              flr_enable,
  input wire logic              vf_count_err
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  // register strobes decoded by word
  wire       ctl_wr = reg_wr && reg_addr[9:2] == {BLK_GLOBAL, GW_CTRL};
  wire       cnt_wr = reg_wr && reg_addr[9:2] == {BLK_GLOBAL, GW_VFCNT};
  wire       st_rd  = reg_rd && reg_addr[9:2] == {BLK_GLOBAL, GW_STATUS};
  wire [3:0] cnt_sum = {1'b0, reg_wdata[2:0]} + {1'b0, reg_wdata[6:4]};

  // lookup answered as a vf of the first function
  sequence s_vf0;
    req_valid ##1 (ans.mapped && ans.is_vf && !ans.pf);
  endsequence

  // lookup and map relations
  chk_ans_one: assert property (req_valid |=> ans_valid)
    else $error("lookup answer missing");
  chk_vf_range: assert property (
    req_valid && (req.fn > VF_LAST_FN || (req.fn > PF1_FN &&
    req.fn < VF_FIRST_FN)) |=> !ans.mapped)
    else $error("function outside vf range mapped");
  chk_pf0_fixed: assert property (
    req_valid && req.fn == PF0_FN |=> ans.mapped && !ans.is_vf && !ans.pf)
    else $error("function zero not first function");
  chk_pf1_fixed: assert property (
    req_valid && req.fn == PF1_FN ##1 ans.mapped |-> ans.pf && !ans.is_vf)
    else $error("function one not second function");
  chk_vf_order: assert property (
    s_vf0 |-> {5'h0, ans.vf_idx} == $past(req.fn) - VF_FIRST_FN)
    else $error("first function vf index wrong");
  chk_claim_slot: assert property (
    ans.claimed |-> ans.bar <= 3'h5 && ans.mapped)
    else $error("claim by nonexistent slot");

  // offsets, counts and capability presence
  chk_off_first: assert property (
    st_rd |=> reg_rdata[7:0] inside {8'h00, 8'h40})
    else $error("first function offset wrong");
  chk_off_second: assert property (
    st_rd |=> reg_rdata[15:8] == 8'h00 ||
    (reg_rdata[15:8] >= 8'h3F && reg_rdata[15:8] <= 8'h44))
    else $error("second function offset wrong");
  chk_cnt_over: assert property (
    cnt_wr && cnt_sum > 4'h6 |-> ##2 vf_count_err)
    else $error("count overflow not flagged");
  chk_root_off: assert property (
    ctl_wr && reg_wdata[1:0] == PORT_ROOT |-> ##2
    (sriov_present == 2'b00 && !flr_enable))
    else $error("root port kept capability or reset");
  chk_cap_on: assert property (
    ctl_wr && reg_wdata[CTRL_SRIOV] && reg_wdata[1:0] == PORT_EP |-> ##2
    sriov_present[0])
    else $error("capability missing on first function");
endmodule

bind srv_sriov_map srv_map_chk u_chk (
  .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .req_valid(req_valid), .req(req), .ans_valid(ans_valid), .ans(ans),
  .sriov_present(sriov_present), .flr_enable(flr_enable),
  .vf_count_err(vf_count_err)
);

`default_nettype wire

// file: test/test_srv_sriov_map.sv
// testbench for the virtual function map block
// assumes the host model issues lookups and the bench drives registers
`timescale 1ns/1ns
`default_nettype none

module test_srv_sriov_map
  import srv_pkg::*;
;
  localparam logic [15:0] DEV_ID = 16'h3C3C; // arbitrary value

  logic              mclk;
  logic              rstn;
  logic              reg_wr;
  logic              reg_rd;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0]       reg_wdata;
  logic [31:0]       reg_rdata;
  logic              req_valid;
  logic              ans_valid;
  srv_req_s          req;
  srv_ans_s          ans;
  logic [1:0]        sriov_present;
  logic              flr_enable;
  logic              vf_count_err;
  int                fail_count;
  int                checks_done;
  logic [31:0]       bcfg [6];
  logic [31:0]       bexp [6];

  // 20 MHz clock
  always #25 mclk = ~mclk;

  srv_sriov_map #(.VF_DEVICE_ID(DEV_ID)) u_dut (
    .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .req_valid(req_valid), .req(req), .ans_valid(ans_valid), .ans(ans),
    .sriov_present(sriov_present), .flr_enable(flr_enable),
    .vf_count_err(vf_count_err));

  srv_host_model u_host (.mclk(mclk), .req_valid(req_valid), .req(req),
    .ans_valid(ans_valid), .ans(ans));

  // compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [9:0] fa(input logic [2:0] b, input logic [4:0] w);
    return {b, w, 2'b00};
  endfunction

  // register write, one strobe cycle
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // register read, data checked in the cycle after the strobe
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    chk(reg_rdata, e);
  endtask

  task automatic look(input logic io, input logic [7:0] fn,
                      input logic [63:0] a, input srv_ans_s e);
    srv_ans_s r;
    u_host.lookup(io, fn, a, r);
    chk({22'h0, r}, {22'h0, e});
  endtask

  // expected answer for a function number with no bar claim
  function automatic srv_ans_s ea(input logic [7:0] fn,
                                  input logic [2:0] n0, input logic [2:0] n1);
    logic [7:0] k;
    k = fn - VF_FIRST_FN;
    if (fn == PF0_FN)
      return 10'h200;
    if (fn == PF1_FN)
      return 10'h280;
    if (k < {5'h0, n0})
      return {3'b110, k[2:0], 4'h0};
    if (k < {5'h0, n0} + {5'h0, n1})
      return {3'b111, k[2:0] - n0, 4'h0};
    return 10'h000;
  endfunction

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog
  initial
  begin
    repeat (6000) @(posedge mclk);
    fail_count++;
    print_verdict();
  end

  // main sequence
  initial
  begin
    mclk = 1'b0;
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    rd(fa(BLK_PF0, LW_CAPVER), 32'h1);
    rd(fa(BLK_PF1, LW_DEVID), {16'h0, DEV_ID});
    rd(fa(BLK_PF0, LW_PAGE), 32'h1);
    rd(fa(BLK_PF0, {LW_BAR_BASE, 3'h0}), 32'h0);
    rd(10'h3FC, 32'h0);
    wr(fa(BLK_PF0, LW_CAPVER), 32'hFFFF_FFF2);
    rd(fa(BLK_PF0, LW_CAPVER), 32'h2);
    wr(fa(BLK_PF1, LW_DEVID), 32'hFFFF_1234);
    rd(fa(BLK_PF1, LW_DEVID), 32'h1234);
    wr(fa(BLK_PF0, LW_PAGE), 32'h8000_0012);
    rd(fa(BLK_PF0, LW_PAGE), 32'h8000_0012);
    $display("test reset values done");
    wr(fa(BLK_GLOBAL, GW_CTRL), 32'h0C);
    wr(fa(BLK_GLOBAL, GW_VFCNT), 32'h32);
    rd(fa(BLK_GLOBAL, GW_STATUS), 32'h0006_4140);
    for (int f = 0; f < 72; f++)
      look(1'b0, 8'(f), 64'h0, ea(8'(f), 3'h2, 3'h3));
    $display("test function map done");
    wr(fa(BLK_GLOBAL, GW_VFCNT), 32'h45);
    rd(fa(BLK_GLOBAL, GW_STATUS), 32'h0007_4440);
    chk({31'h0, vf_count_err}, 32'h1);
    for (int f = 0; f < 72; f++)
      look(1'b0, 8'(f), 64'h0, ea(8'(f), 3'h5, 3'h1));
    $display("test count clamp done");
    bcfg = '{32'h207, 32'h247, 32'h2A6, 32'h0, 32'h307, 32'h247};
    bexp = '{32'hFFFF_FF80, 32'h0, 32'h4, 32'hFFFF_FFC0, 32'h0,
             32'hFFFF_FF88};
    for (int i = 0; i < 6; i++)
    begin
      wr(fa(BLK_PF0, {LW_BAR_CFG, 3'(i)}), bcfg[i]);
      wr(fa(BLK_PF0, {LW_BAR_BASE, 3'(i)}), 32'hFFFF_FFFF);
      rd(fa(BLK_PF0, {LW_BAR_BASE, 3'(i)}), bexp[i]);
    end
    bcfg = '{32'h220, 32'h206, 32'h007, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 3; i++)
    begin
      wr(fa(BLK_PF0, {LW_BAR_CFG, 3'h0}), bcfg[i]);
      rd(fa(BLK_PF0, {LW_BAR_BASE, 3'h0}), 32'h0);
    end
    wr(fa(BLK_PF0, {LW_BAR_CFG, 3'h0}), 32'h207);
    wr(fa(BLK_PF0, {LW_BAR_BASE, 3'h0}), 32'h1000_0000);
    look(1'b0, 8'h40, 64'h1000_0000, 10'h308);
    look(1'b0, 8'h41, 64'h1000_0080, 10'h318);
    look(1'b1, 8'h41, 64'h1000_0080, 10'h310);
    $display("test vf bars done");
    wr(fa(BLK_GLOBAL, GW_CTRL), 32'h1E);
    rd(fa(BLK_PF0, {LW_BAR_BASE, 3'h0}), 32'h0);
    chk({28'h0, vf_count_err, flr_enable, sriov_present}, 32'h8);
    wr(fa(BLK_GLOBAL, GW_CTRL), 32'h1C);
    rd(fa(BLK_GLOBAL, GW_CTRL), 32'h1C);
    chk({28'h0, vf_count_err, flr_enable, sriov_present}, 32'hF);
    $display("test port types done");
    wr(fa(BLK_GLOBAL, GW_CTRL), 32'h1D);
    wr(fa(BLK_PF0, {LW_BAR_CFG, 3'h4}), 32'h304);
    wr(fa(BLK_PF0, {LW_BAR_BASE, 3'h4}), 32'h0000_2000);
    rd(fa(BLK_PF0, {LW_BAR_BASE, 3'h4}), 32'h0000_2001);
    look(1'b1, 8'h40, 64'h2000, 10'h30C);
    wr(fa(BLK_PF0, LW_MTBL), 32'h0001_0007);
    wr(fa(BLK_PF0, LW_MTOFF), 32'h3);
    rd(fa(BLK_GLOBAL, GW_STATUS), 32'h001F_4440);
    wr(fa(BLK_PF0, LW_MTOFF), 32'h0);
    rd(fa(BLK_GLOBAL, GW_STATUS), 32'h000F_4440);
    rd(fa(BLK_PF0, LW_MTBL), 32'h0001_0007);
    wr(fa(BLK_GLOBAL, GW_CTRL), 32'h1F);
    rd(fa(BLK_GLOBAL, GW_CTRL), 32'h1D);
    wr(fa(BLK_GLOBAL, GW_CTRL), 32'h15);
    rd(fa(BLK_GLOBAL, GW_STATUS), 32'h000B_0040);
    look(1'b0, 8'h01, 64'h0, 10'h000);
    $display("test legacy and msi-x done");
    print_verdict();
  end
endmodule

`default_nettype wire
